// ---- interrupt_vector_control_test.sv ----
// self-checking test of the interrupt vector block
`timescale 1ns/1ps
`default_nettype none
`include "ivc_map.vh"
module interrupt_vector_control_test;
    logic mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0;
    logic tick = 1'b0, do_retfi = 1'b0, do_sleep = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, tcnt = 8'h00;
    logic [3:0] pb = 4'h0;
    logic [11:0] pev = 12'h000;
    wire [7:0] rdata;
    wire [12:0] vpc, pdata, pc;
    wire take, push, wake, asleep, irq, idone, retfi, slp;
    int error_cnt = 0, checked = 0, n;
    localparam [8:0] CTL = `IVC_OFF_IRQ_CONTROL;

    ivc_top #(.NPER(12)) u_ivc_top (.MCLK(mclk), .RESETN(resetn),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .EXT_IRQ_PIN(pin), .PORT_B_HI(pb), .PERIPH_EVENT(pev),
        .TMR_TICK(tick), .TIMER_ZERO_COUNT(tcnt), .CORE_PC(pc),
        .INSTR_DONE(idone), .RETFI_EXEC(retfi), .SLEEP_EXEC(slp),
        .VECTOR_TAKE(take), .VECTOR_PC(vpc), .PUSH_STB(push),
        .PUSH_DATA(pdata), .WAKE(wake), .ASLEEP(asleep), .IRQ(irq));
    ivc_core_model u_ivc_core_model (.clk(mclk), .rst_n(resetn),
        .take(take), .asleep(asleep), .do_retfi(do_retfi),
        .do_sleep(do_sleep), .instr_done(idone), .core_pc(pc),
        .retfi_exec(retfi), .sleep_exec(slp));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    task chk(input string nm, input logic [12:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr_reg(input logic [8:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe
    task rd_reg(input logic [8:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", rdata, e);
        @(posedge mclk);
    endtask
    // bounded wait on take or wake, sampled mid-cycle
    task upto(input bit w, input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while ((w ? wake : take) !== 1'b1 && n < lim);
        @(posedge mclk);
    endtask
    task close_out;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog well past the hundred-odd cycles of the tests
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        close_out;
    end

    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_reg(CTL, 8'h00);
        rd_reg(`IVC_OFF_OPTION, 8'hff);
        rd_reg(`IVC_OFF_ENABLE_A, 8'h00);
        rd_reg(9'h030, 8'h00);
        wr_reg(9'h070, 8'ha5);
        rd_reg(9'h0f0, 8'ha5);
        wr_reg(CTL, 8'h90);
        pin <= 1'b1;
        upto(0, 40);
        chk("lat", n >= 10 && n <= 20, 1);
        chk("vpc", vpc, 13'h0004);
        rd_reg(CTL, 8'h12);
        wr_reg(CTL, 8'h10);
        do_retfi <= 1'b1;
        repeat (4) @(posedge mclk);
        do_retfi <= 1'b0;
        rd_reg(CTL, 8'h90);
        wr_reg(`IVC_OFF_OPTION, 8'hbf);
        wr_reg(CTL, 8'h10);
        pin <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_reg(CTL, 8'h12);
        chk("irq", irq, 0);
        wr_reg(CTL, 8'h10);
        pin <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_reg(CTL, 8'h10);
        tcnt <= 8'hff;
        tick <= 1'b1;
        @(posedge mclk);
        tcnt <= 8'h00;
        @(posedge mclk);
        tick <= 1'b0;
        rd_reg(CTL, 8'h14);
        wr_reg(CTL, 8'h00);
        pb <= 4'h8;
        repeat (6) @(posedge mclk);
        rd_reg(CTL, 8'h01);
        wr_reg(CTL, 8'h00);
        pev <= 12'h101;
        @(posedge mclk);
        pev <= 12'h000;
        rd_reg(`IVC_OFF_FLAG_A, 8'h01);
        rd_reg(`IVC_OFF_FLAG_B, 8'h01);
        wr_reg(`IVC_OFF_ENABLE_A, 8'h01);
        wr_reg(CTL, 8'h80);
        repeat (4) @(posedge mclk);
        chk("irq", irq, 0);
        wr_reg(CTL, 8'hc0);
        upto(0, 20);
        chk("take", n < 20, 1);
        rd_reg(CTL, 8'h40);
        wr_reg(`IVC_OFF_FLAG_A, 8'h00);
        wr_reg(`IVC_OFF_FLAG_B, 8'h00);
        wr_reg(CTL, 8'h10);
        do_sleep <= 1'b1;
        repeat (4) @(posedge mclk);
        do_sleep <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk("asleep", asleep, 1);
        @(posedge mclk);
        pin <= 1'b0;
        upto(1, 20);
        chk("wake", n < 20, 1);
        wr_reg(CTL, 8'h80);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_reg(CTL, 8'h00);
        close_out;
    end
endmodule // interrupt_vector_control_test
`default_nettype wire

// ---- ivc_core_model.sv ----
// core model: instruction boundaries, program counter, retfi, sleep
`timescale 1ns/1ps
`default_nettype none
module ivc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // from the interrupt block and the bench
    input wire logic take,
    input wire logic asleep,
    input wire logic do_retfi,
    input wire logic do_sleep,
    // to the interrupt block
    output logic instr_done,
    output logic [12:0] core_pc,
    output logic retfi_exec,
    output logic sleep_exec
);
    logic [1:0] ph_reg;
    // four clocks per instruction; pc jumps on entry
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg <= 2'h0;
            core_pc <= 13'h0000;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            if (take)
                core_pc <= 13'h0004;
            else if (instr_done)
                core_pc <= core_pc + 13'h0001;
        end
    end
    // no boundaries while the clock is stopped in sleep
    assign instr_done = (ph_reg == 2'h3) && !asleep;
    // only the pc lives here; no context is saved on entry
    assign retfi_exec = instr_done && do_retfi;
    assign sleep_exec = instr_done && do_sleep;
endmodule // ivc_core_model
`default_nettype wire

// ---- ivc_map.vh ----
// register offsets, bit positions and timing constants of the interrupt block
`ifndef IVC_MAP_VH
`define IVC_MAP_VH
// register offsets on the plain port
`define IVC_OFF_IRQ_CONTROL 8'h0b
`define IVC_OFF_FLAG_A 8'h0c
`define IVC_OFF_FLAG_B 8'h0d
`define IVC_OFF_OPTION 8'h81
`define IVC_OFF_ENABLE_A 8'h8c
`define IVC_OFF_ENABLE_B 8'h8d
`define IVC_OFF_CORE_STATUS 8'h40
`define IVC_OFF_COMMON_BASE 8'h70
`define IVC_COMMON_MASK 8'hf0
// control and option register fields
`define IVC_BIT_GIE 7
`define IVC_BIT_PERIPH_GROUP_ENABLE 6
`define IVC_BIT_TIMER_ZERO_ENABLE 5
`define IVC_BIT_EXTIE 4
`define IVC_BIT_PCIE 3
`define IVC_BIT_TIMER_ZERO_FLAG 2
`define IVC_BIT_EXTIF 1
`define IVC_BIT_PCIF 0
`define IVC_BIT_EDGE 6
// reset values
`define IVC_RST_CONTROL 8'h00
`define IVC_RST_OPTION 8'hff
`define IVC_RST_PERIPH 8'h00
// vector and timer wrap value
`define IVC_VECTOR 13'h0004
`define IVC_TMR_TOP 8'hff
// latency in instruction cycles, and instruction cycle length in clocks
`define IVC_LAT_CYC 3
`define IVC_ICYC_CLK 4
`endif

// ---- ivc_top.v ----
// interrupt flag, enable, sleep-wake and vector logic of a small core
// Functional notes
// RL1: up to nineteen sources, each with its own flag and enable bit; the default build has fifteen (three core, twelve peripheral), NPER up to 16 gives nineteen.
// RL2: flags set on their event regardless of any enable.
// RL3: global enable at control bit 7 gates every request.
// RL4: enabled pending request with global enable set takes the vector.
// RL5: any reset clears the global enable.
// RL6: return-from-interrupt sets the global enable again.
// RL7: peripheral flags/enables in two register pairs, also need group enable.
// RL8: on entry clear global enable, push return address, jump to 0004h.
// RL9: software clears flags before re-enabling, avoiding re-entry.
// RL10: pin-edge and port-change latency is three or four instruction cycles.
// RL11: external pin edge chosen by option bit 6, rising when set.
// RL12: valid edge sets control bit 1; enable at bit 4 masks it.
// RL13: external pin wakes from sleep if enabled; global enable picks vector.
// RL14: timer wrap from FFh to 00h sets bit 2, gated by bit 5.
// RL15: change on upper port pins sets bit 0, gated by own enable.
// RL16: entry saves only the return address; software saves the rest.
// RL17: top sixteen bytes of every bank map to one common area.
// RL18: enabled request wakes sleep; vector after next instruction if enabled.
// RL19: request is OR of enabled core and group-gated peripheral terms.
//
// Our own choice: the plain strobed port.
`include "ivc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ivc_top #(
    parameter NPER = 12
) (
    // clock and reset
    input wire MCLK,
    input wire RESETN,
    // register port
    input wire [8:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // pins
    input wire EXT_IRQ_PIN,
    input wire [3:0] PORT_B_HI,
    // peripheral event pulses and timer
    input wire [NPER-1:0] PERIPH_EVENT,
    input wire TMR_TICK,
    input wire [7:0] TIMER_ZERO_COUNT,
    // core handshake
    input wire [12:0] CORE_PC,
    input wire INSTR_DONE,
    input wire RETFI_EXEC,
    input wire SLEEP_EXEC,
    // to core
    output reg VECTOR_TAKE,
    output reg [12:0] VECTOR_PC,
    output reg PUSH_STB,
    output reg [12:0] PUSH_DATA,
    output reg WAKE,
    output reg ASLEEP,
    output reg IRQ
);
    // block overview
    // the control word holds the global enable, the group enable, three
    // core source enables and their three flags; the peripheral sources
    // live in two flag and enable register pairs, eight bits each
    //
    // register map on the plain port, low eight address bits decoded:
    //   control word, peripheral flags a and b, option word,
    //   peripheral enables a and b, core status, common area
    // the bank bit of the address is ignored only by the common area,
    // so the common area alone shows in both banks
    // core status reads {pending pin event, wake to vector, asleep}
    //
    // write behaviour:
    //   a write lands at the edge that samples the strobe
    //   a hardware flag set in that same cycle beats the written zero,
    //   so an event is never lost to a racing clear
    //   entry clearing the global enable beats a same-cycle write
    //   and a same-cycle return-from-interrupt, so no double entry
    //
    // read behaviour:
    //   read data stand for one cycle after the strobe, zero otherwise;
    //   a held-zero bus keeps an or-tree on the far side simple
    //
    // entry timing:
    //   a pin edge needs two synchroniser flops and one history flop
    //   before the flag sets; the latency counter then lets two
    //   instruction boundaries pass, and the third takes the vector,
    //   which lands the entry three or four instruction cycles after
    //   the event depending on where in an instruction it arrives
    //   a request from a flag set by software or a timer wrap is taken
    //   at the next boundary, since the counter is already at zero
    //   the take pulse and the push strobe stand for one cycle only
    //
    // sleep:
    //   sleep is refused, acting as a no-op, while a request stands;
    //   this avoids sleeping through an event that raced the sleep
    //   any enabled request wakes the core whatever the global enable;
    //   with the global enable set the next instruction runs first; after a software, timer or peripheral
    //   wake the vector is taken at the following boundary, after a pin or port-change wake only once the latency count expires
    //   no vector is taken while asleep, as no boundary comes then
    //
    // limitations:
    //   only the return address is pushed; the working and status
    //   registers are the service routine's business
    //   the timer count is sampled only on its tick pulse, so a wrap
    //   seen without a tick is ignored
    //   at most sixteen peripheral sources fit the two flag registers;
    //   with the default twelve, the top four bits of the second pair
    //   are plain storage with no event behind them
    //   the common area has no reset, as software saves into it
    //   before it reads it back
    //
    // reset:
    //   the reset input is released through two flops, so every flop
    //   below but the common area leaves reset on the same edge and no half state shows
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    reg [1:0] ext_s_reg;
    reg [7:0] pb_s_reg;
    reg ext_prev_reg;
    reg [3:0] pb_prev_reg;
    reg [7:0] ctrl_reg;
    reg [7:0] opt_reg;
    reg [7:0] flag_a_reg;
    reg [7:0] flag_b_reg;
    reg [7:0] en_a_reg;
    reg [7:0] en_b_reg;
    reg [7:0] tmr_prev_reg;
    reg [7:0] common_reg [0:15];
    reg [1:0] lat_reg;
    reg pend_ext_reg;
    reg rd_pend_reg;
    reg [8:0] rd_addr_reg;
    reg sleep_reg;
    reg wake_vec_reg;
    // latency reload value, cut to the two-bit counter on purpose
    localparam integer LAT_CYC = `IVC_LAT_CYC;
    wire [1:0] lat_load = LAT_CYC[1:0] - 2'h1;

    // register selection shared by read and write paths
    function sel;
        input [8:0] a;
        input [7:0] off;
        begin
            sel = (a[7:0] == off);
        end
    endfunction

    // reset release through two flops
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // pin synchronisers; first stage read only by second
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_s_reg <= 2'h0;
            pb_s_reg <= 8'h00;
        end else begin
            ext_s_reg <= {ext_s_reg[0], EXT_IRQ_PIN};
            pb_s_reg <= {pb_s_reg[3:0], PORT_B_HI};
        end
    end

    wire ext_now = ext_s_reg[1];
    wire [3:0] pb_now = pb_s_reg[7:4];
    // edge polarity selected by the option bit
    wire edge_sel = opt_reg[`IVC_BIT_EDGE];
    wire ext_edge = edge_sel ? (ext_now & ~ext_prev_reg) :
        (~ext_now & ext_prev_reg); // RL11
    wire pb_chg = |(pb_now ^ pb_prev_reg); // RL15
    wire tmr_wrap = TMR_TICK & (tmr_prev_reg == `IVC_TMR_TOP) &
        (TIMER_ZERO_COUNT == 8'h00); // RL14

    // enabled-request terms
    wire core_req = (ctrl_reg[`IVC_BIT_TIMER_ZERO_FLAG] & ctrl_reg[`IVC_BIT_TIMER_ZERO_ENABLE]) |
        (ctrl_reg[`IVC_BIT_EXTIF] & ctrl_reg[`IVC_BIT_EXTIE]) |
        (ctrl_reg[`IVC_BIT_PCIF] & ctrl_reg[`IVC_BIT_PCIE]);
    wire per_req = ctrl_reg[`IVC_BIT_PERIPH_GROUP_ENABLE] &
        (|(flag_a_reg & en_a_reg) | |(flag_b_reg & en_b_reg)); // RL7
    wire any_req = core_req | per_req; // RL19
    wire global_irq_enable = ctrl_reg[`IVC_BIT_GIE];
    wire go_req = global_irq_enable & any_req; // RL3
    // vector taken at an instruction boundary, after the latency count
    wire take = go_req & INSTR_DONE & (lat_reg == 2'h0) & ~sleep_reg &
        ~VECTOR_TAKE; // RL4

    wire wr_ctrl = WR & sel(ADDR, `IVC_OFF_IRQ_CONTROL);
    wire wr_fa = WR & sel(ADDR, `IVC_OFF_FLAG_A);
    wire wr_fb = WR & sel(ADDR, `IVC_OFF_FLAG_B);
    // enable and option writes
    wire wr_ea = WR & sel(ADDR, `IVC_OFF_ENABLE_A);
    wire wr_eb = WR & sel(ADDR, `IVC_OFF_ENABLE_B);
    wire wr_opt = WR & sel(ADDR, `IVC_OFF_OPTION);
    wire [15:0] pev = {{(16 - NPER){1'b0}}, PERIPH_EVENT};
    // common area hit; bank bit dropped so both banks share it
    wire [7:0] com_mask = `IVC_COMMON_MASK;
    wire [7:0] com_base = `IVC_OFF_COMMON_BASE;
    wire com_hit = (({1'b0, ADDR[6:0]}) & com_mask) == com_base; // RL17

    // control word; hardware set wins over software write
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `IVC_RST_CONTROL; // RL5
        end else begin
            if (wr_ctrl)
                ctrl_reg <= WDATA;
            if (take)
                ctrl_reg[`IVC_BIT_GIE] <= 1'b0; // RL8
            else if (RETFI_EXEC)
                ctrl_reg[`IVC_BIT_GIE] <= 1'b1; // RL6
            if (ext_edge)
                ctrl_reg[`IVC_BIT_EXTIF] <= 1'b1; // RL12 RL2
            if (tmr_wrap)
                ctrl_reg[`IVC_BIT_TIMER_ZERO_FLAG] <= 1'b1; // RL14 RL2
            if (pb_chg)
                ctrl_reg[`IVC_BIT_PCIF] <= 1'b1; // RL15 RL2
        end
    end

    // peripheral flags; an event in the cycle of a clear still lands
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_a_reg <= `IVC_RST_PERIPH;
            flag_b_reg <= `IVC_RST_PERIPH;
        end else begin
            flag_a_reg <= (wr_fa ? WDATA : flag_a_reg) | pev[7:0]; // RL1 RL2
            flag_b_reg <= (wr_fb ? WDATA : flag_b_reg) | pev[15:8]; // RL1
        end
    end

    // peripheral enables, plain software storage
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            en_a_reg <= `IVC_RST_PERIPH;
            en_b_reg <= `IVC_RST_PERIPH;
        end else begin
            if (wr_ea)
                en_a_reg <= WDATA; // RL7
            if (wr_eb)
                en_b_reg <= WDATA; // RL7
        end
    end

    // option word; only the edge select bit is used here
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            opt_reg <= `IVC_RST_OPTION;
        end else if (wr_opt) begin
            opt_reg <= WDATA; // RL11
        end
    end

    // common area shared by every bank, reached without bank bits
    always @(posedge MCLK) begin
        if (WR && com_hit)
            common_reg[ADDR[3:0]] <= WDATA; // RL17
    end

    // history for edge, change and wrap detection
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_reg <= 1'b0;
            pb_prev_reg <= 4'h0;
            tmr_prev_reg <= 8'h00;
        end else begin
            ext_prev_reg <= ext_now;
            pb_prev_reg <= pb_now;
            if (TMR_TICK)
                tmr_prev_reg <= TIMER_ZERO_COUNT;
        end
    end

    // latency counter: external events wait a few instruction boundaries
    // so entry falls three or four instruction cycles after the pin event
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            lat_reg <= 2'h0;
            pend_ext_reg <= 1'b0;
        end else if (ext_edge || pb_chg) begin
            lat_reg <= lat_load; // RL10
            pend_ext_reg <= 1'b1;
        end else if (INSTR_DONE && lat_reg != 2'h0) begin
            lat_reg <= lat_reg - 2'h1; // RL10
        end else if (lat_reg == 2'h0) begin
            pend_ext_reg <= 1'b0;
        end
    end

    // sleep and wake; wake does not look at the global enable
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= 1'b0;
            wake_vec_reg <= 1'b0;
        end else if (sleep_reg && any_req) begin
            sleep_reg <= 1'b0; // RL18 RL13
            wake_vec_reg <= global_irq_enable; // RL18
        end else if (SLEEP_EXEC && !any_req) begin
            sleep_reg <= 1'b1; // pending request makes sleep a no-op
        end else if (INSTR_DONE) begin
            wake_vec_reg <= 1'b0; // next instruction ran, take applies
        end
    end

    // core-facing entry outputs; only the return address is pushed
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            VECTOR_TAKE <= 1'b0;
            VECTOR_PC <= 13'h0000;
            PUSH_STB <= 1'b0;
            PUSH_DATA <= 13'h0000;
        end else begin
            VECTOR_TAKE <= take; // RL8
            VECTOR_PC <= `IVC_VECTOR; // RL8
            PUSH_STB <= take; // RL16
            if (take)
                PUSH_DATA <= CORE_PC; // RL16
        end
    end

    // sleep indications for the core clock gating
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            WAKE <= 1'b0;
            ASLEEP <= 1'b0;
        end else begin
            WAKE <= sleep_reg & any_req; // RL18
            ASLEEP <= sleep_reg;
        end
    end

    // level request, registered so the pin never glitches
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n)
            IRQ <= 1'b0;
        else
            IRQ <= go_req; // RL19
    end

    // read path, data one cycle after the strobe
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (com_hit)
                RDATA <= common_reg[ADDR[3:0]];
            else if (sel(ADDR, `IVC_OFF_IRQ_CONTROL))
                RDATA <= ctrl_reg;
            else if (sel(ADDR, `IVC_OFF_FLAG_A))
                RDATA <= flag_a_reg;
            else if (sel(ADDR, `IVC_OFF_FLAG_B))
                RDATA <= flag_b_reg;
            else if (sel(ADDR, `IVC_OFF_ENABLE_A))
                RDATA <= en_a_reg;
            else if (sel(ADDR, `IVC_OFF_ENABLE_B))
                RDATA <= en_b_reg;
            else if (sel(ADDR, `IVC_OFF_OPTION))
                RDATA <= opt_reg;
            else if (sel(ADDR, `IVC_OFF_CORE_STATUS))
                RDATA <= {5'h00, pend_ext_reg, wake_vec_reg, sleep_reg};
            else
                RDATA <= 8'h00; // unmapped reads as zero
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // ivc_top
`default_nettype wire

// ---- ivc_top_asserts.sv ----
// assertion checker for the interrupt vector block
`timescale 1ns/1ps
`default_nettype none
module ivc_top_asserts (
    // clock and reset
    input wire MCLK,
    input wire RESETN,
    // core handshake
    input wire INSTR_DONE,
    // to core
    input wire VECTOR_TAKE,
    input wire [12:0] VECTOR_PC,
    input wire PUSH_STB,
    input wire WAKE,
    input wire ASLEEP,
    input wire IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_push_at_take: assert property (VECTOR_TAKE |-> PUSH_STB)
        else $error("no push at take");
    a_push_only_take: assert property (PUSH_STB |-> VECTOR_TAKE)
        else $error("push without take");
    a_vector_addr: assert property (VECTOR_TAKE |-> VECTOR_PC == 13'h0004)
        else $error("bad vector");
    a_take_on_boundary: assert property (VECTOR_TAKE |-> $past(INSTR_DONE))
        else $error("take off boundary");
    a_take_single: assert property (VECTOR_TAKE |=> !VECTOR_TAKE)
        else $error("take too long");
    // global enable cleared on entry must drop the request
    a_take_drops_irq: assert property (VECTOR_TAKE |-> ##2 !IRQ)
        else $error("irq after take");
    a_wake_when_asleep: assert property (WAKE |-> ASLEEP)
        else $error("wake while awake");
    a_no_take_asleep: assert property (ASLEEP |-> !VECTOR_TAKE)
        else $error("take while asleep");
endmodule // ivc_top_asserts
bind ivc_top ivc_top_asserts u_ivc_top_asserts (.MCLK(MCLK), .RESETN(RESETN),
    .INSTR_DONE(INSTR_DONE), .VECTOR_TAKE(VECTOR_TAKE),
    .VECTOR_PC(VECTOR_PC), .PUSH_STB(PUSH_STB), .WAKE(WAKE),
    .ASLEEP(ASLEEP), .IRQ(IRQ));
`default_nettype wire
